// ### src/eqrqs_pkg.sv
// constants and carrier types for the egress qos remap and queue scheduler
package eqrqs_pkg;
  localparam int NPORT = 12;
  localparam int NQ = 8;
  localparam int QDEPTH = 4;
  localparam int PORT_W = 4;
  localparam int Q_W = 3;
  localparam int PTR_W = 8;
  localparam int CELL_W = 4;
  localparam int FREE_W = 11;
  localparam int BUF_CELLS = 1024;
  localparam int AW = 16;
  localparam logic [7:0] ENQ_EN_RST = 8'hff;
  // register byte offsets
  localparam int A_CTRL = 'h000;
  localparam int A_FREE = 'h004;
  localparam int A_MINFREE = 'h008;
  localparam int A_EMPTY = 'h00c;
  localparam int A_PORT = 'h100;
  localparam int A_QDEPTH = 'h800;
  localparam int PSTRIDE = 'h20;
  localparam int F_OUTDIS = 'h00;
  localparam int F_ENQEN = 'h04;
  localparam int F_DRAIN = 'h08;
  localparam int F_PCFG = 'h0c;
  localparam int F_PDEPTH = 'h10;
  localparam int F_QOFF = 'h14;
  localparam int F_DDROP = 'h18;
  localparam int A_RQV = 'h1000;
  localparam int A_QPD = 'h1040;
  localparam int A_QEXP = 'h1080;
  localparam int A_SEL = 'h2000;
  localparam int A_MAP = 'h3000;
  localparam int SEL_N = NPORT * 16;
  localparam int MAP_N = 128;
  localparam int MAP_EW = 15;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {EQRQS_OTHER, EQRQS_IPV4, EQRQS_IPV6,
    EQRQS_MPLS} eqrqs_pkt_e;
  typedef enum logic [1:0] {EQRQS_SWITCHED, EQRQS_ROUTED,
    EQRQS_CLASSIFIED, EQRQS_FWD_RSV} eqrqs_fwd_e;
  typedef enum logic [1:0] {EQRQS_OP_NONE, EQRQS_OP_PUSH, EQRQS_OP_SWAP,
    EQRQS_OP_POP} eqrqs_op_e;
  typedef enum logic [1:0] {EQRQS_MAP_L2, EQRQS_MAP_IP, EQRQS_MAP_TOS,
    EQRQS_MAP_MPLS} eqrqs_map_e;
  typedef enum {RG_NONE, RG_CTRL, RG_FREE, RG_MINFREE, RG_EMPTY, RG_OUTDIS,
    RG_ENQEN, RG_DRAIN, RG_PCFG, RG_PDEPTH, RG_QOFF, RG_DDROP, RG_QDEPTH,
    RG_RQV, RG_QPD, RG_QEXP, RG_SEL, RG_MAP} eqrqs_reg_e;
  typedef struct packed {
    logic [PORT_W-1:0] port;
    logic [Q_W-1:0] queue;
    logic [PTR_W-1:0] ptr;
    logic [CELL_W-1:0] cells;
    eqrqs_pkt_e pkt_type;
    eqrqs_fwd_e fwd_type;
    logic [2:0] pcp;
    logic dei;
    logic [2:0] exp;
    logic [7:0] tos;
    logic add_inner_next_hop_tag;
    logic add_outer_next_hop_tag;
    logic inner_tag_priority_source;
    logic outer_tag_priority_source;
    logic inner_tag_drop_bit_source;
    logic outer_tag_drop_bit_source;
    eqrqs_op_e label_operation;
    logic label_class_source;
  } eqrqs_enq_s;
  typedef struct packed {
    logic [PORT_W-1:0] port;
    logic [Q_W-1:0] queue;
    logic [PTR_W-1:0] ptr;
    logic [CELL_W-1:0] cells;
    logic strip_tags;
    logic add_inner;
    logic add_outer;
    logic [2:0] inner_pcp;
    logic inner_dei;
    logic [2:0] outer_pcp;
    logic outer_dei;
    logic [2:0] pcp;
    logic dei;
    logic [2:0] exp;
    logic [7:0] tos;
  } eqrqs_out_s;
  typedef struct packed {
    eqrqs_op_e port_tag_operation;
    logic port_priority_source;
    logic port_drop_bit_source;
  } eqrqs_pcfg_s;
  typedef struct packed {
    eqrqs_map_e kind;
    logic mapping_table_pointer;
  } eqrqs_sel_s;
  typedef struct packed {
    logic [2:0] exp;
    logic dei;
    logic [2:0] pcp;
    logic [7:0] tos;
  } eqrqs_map_s;
endpackage

// ### src/eqrqs_top.sv
// egress qos remap, strict priority queue scheduler and queue management
// Contract
// - queue remaps first; table mapping only when second stage enable is one
// - routed packets lose original tags; up to two next-hop tags added
// - added next-hop tag pcp from router queue table when chosen
// - added next-hop tag drop bit from router queue table when chosen
// - push/swap port tag pcp from queue-to-pcp table when chosen
// - push/swap port tag drop bit from queue-to-pcp table when chosen
// - push/swap label class from queue-to-exp table when chosen
// - selection index from port, packet type and forwarding type
// - two l2 mapping tables picked by the table pointer
// - ip table remaps ecn bits; tos[7:2] kept from color remap
// - tos table replaces whole tos plus pcp, dei, exp into tunnel
// - mpls table remaps pcp, dei and exp
// - second stage inputs are first stage pcp, dei or exp and color tos
// - queue zero highest priority, queue seven lowest
// - strict priority, highest non-empty queue not output disabled always served first
// - expose port depth, queue depth, free cells and minimum free
// - output disabled queue keeps packets but schedules none
// - enqueue disabled queue drops arrivals and counts queue-off drops
// - drain discards all queued packets of a port and counts them
// - per-port status bit high when all its queues are empty
// - eight fifo queues per port, order never changes
`timescale 1ns/10ps
module eqrqs_top #(
  parameter int NPORT = eqrqs_pkg::NPORT,
  parameter int QDEPTH = eqrqs_pkg::QDEPTH,
  parameter int BUF_CELLS = eqrqs_pkg::BUF_CELLS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [eqrqs_pkg::AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [eqrqs_pkg::AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire eqrqs_pkg::eqrqs_enq_s enq_data,
  input wire logic enq_valid,
  output logic enq_ready,
  output eqrqs_pkg::eqrqs_out_s out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int NQ = eqrqs_pkg::NQ;
  localparam int QA_W = $clog2(QDEPTH);
  localparam int CNT_W = $clog2(QDEPTH + 1);
  localparam int FW = eqrqs_pkg::FREE_W;
  localparam int CELL_W_L = eqrqs_pkg::CELL_W;
  localparam logic [CELL_W_L-1:0] CMAX = '1;

  typedef struct packed {
    eqrqs_pkg::eqrqs_reg_e rg;
    logic [eqrqs_pkg::PORT_W-1:0] port;
    logic [eqrqs_pkg::Q_W-1:0] q;
    logic [7:0] idx;
  } eqrqs_dec_s;

  // control and table state
  logic map_en_ff;
  logic [NQ-1:0] out_dis_ff [NPORT];
  logic [NQ-1:0] enq_en_ff [NPORT];
  logic [NPORT-1:0] drain_ff;
  eqrqs_pkg::eqrqs_pcfg_s pcfg_ff [NPORT];
  logic [3:0] rqv_ff [NQ];
  logic [3:0] qpd_ff [NQ];
  logic [2:0] qexp_ff [NQ];
  eqrqs_pkg::eqrqs_sel_s sel_ff [eqrqs_pkg::SEL_N];
  eqrqs_pkg::eqrqs_map_s map_ff [eqrqs_pkg::MAP_N];
  // queue state
  eqrqs_pkg::eqrqs_enq_s qmem_ff [NPORT][NQ][QDEPTH];
  logic [QA_W-1:0] wp_ff [NPORT][NQ];
  logic [QA_W-1:0] rp_ff [NPORT][NQ];
  logic [CNT_W-1:0] cnt_ff [NPORT][NQ];
  logic [FW-1:0] free_ff;
  logic [FW-1:0] min_free_ff;
  logic [NPORT-1:0] empty_ff;
  logic [31:0] qoff_ff [NPORT];
  logic [31:0] ddrop_ff [NPORT];
  logic [eqrqs_pkg::PORT_W-1:0] rr_ff;
  // bus state
  logic aw_have_ff;
  logic w_have_ff;
  logic [eqrqs_pkg::AW-1:0] waddr_ff;
  logic [31:0] wdat_ff;
  logic [3:0] wstb_ff;

  function automatic eqrqs_dec_s decode(logic [eqrqs_pkg::AW-1:0] a);
    eqrqs_dec_s d;
    int ai;
    int off;
    d.rg = eqrqs_pkg::RG_NONE;
    d.port = '0;
    d.q = '0;
    d.idx = '0;
    ai = int'(a);
    if (a[1:0] == 2'h0) begin
      if (ai == eqrqs_pkg::A_CTRL) d.rg = eqrqs_pkg::RG_CTRL;
      else if (ai == eqrqs_pkg::A_FREE) d.rg = eqrqs_pkg::RG_FREE;
      else if (ai == eqrqs_pkg::A_MINFREE) d.rg = eqrqs_pkg::RG_MINFREE;
      else if (ai == eqrqs_pkg::A_EMPTY) d.rg = eqrqs_pkg::RG_EMPTY;
      else if (ai >= eqrqs_pkg::A_PORT &&
          ai < eqrqs_pkg::A_PORT + NPORT * eqrqs_pkg::PSTRIDE) begin
        off = ai - eqrqs_pkg::A_PORT;
        d.port = eqrqs_pkg::PORT_W'(off / eqrqs_pkg::PSTRIDE);
        case (off % eqrqs_pkg::PSTRIDE)
          eqrqs_pkg::F_OUTDIS: d.rg = eqrqs_pkg::RG_OUTDIS;
          eqrqs_pkg::F_ENQEN: d.rg = eqrqs_pkg::RG_ENQEN;
          eqrqs_pkg::F_DRAIN: d.rg = eqrqs_pkg::RG_DRAIN;
          eqrqs_pkg::F_PCFG: d.rg = eqrqs_pkg::RG_PCFG;
          eqrqs_pkg::F_PDEPTH: d.rg = eqrqs_pkg::RG_PDEPTH;
          eqrqs_pkg::F_QOFF: d.rg = eqrqs_pkg::RG_QOFF;
          eqrqs_pkg::F_DDROP: d.rg = eqrqs_pkg::RG_DDROP;
          default: d.rg = eqrqs_pkg::RG_NONE;
        endcase
      end else if (ai >= eqrqs_pkg::A_QDEPTH &&
          ai < eqrqs_pkg::A_QDEPTH + NPORT * eqrqs_pkg::PSTRIDE) begin
        off = ai - eqrqs_pkg::A_QDEPTH;
        d.rg = eqrqs_pkg::RG_QDEPTH;
        d.port = eqrqs_pkg::PORT_W'(off / eqrqs_pkg::PSTRIDE);
        d.q = eqrqs_pkg::Q_W'((off % eqrqs_pkg::PSTRIDE) / 4);
      end else if (ai >= eqrqs_pkg::A_RQV &&
          ai < eqrqs_pkg::A_RQV + NQ * 4) begin
        d.rg = eqrqs_pkg::RG_RQV;
        d.q = eqrqs_pkg::Q_W'((ai - eqrqs_pkg::A_RQV) / 4);
      end else if (ai >= eqrqs_pkg::A_QPD &&
          ai < eqrqs_pkg::A_QPD + NQ * 4) begin
        d.rg = eqrqs_pkg::RG_QPD;
        d.q = eqrqs_pkg::Q_W'((ai - eqrqs_pkg::A_QPD) / 4);
      end else if (ai >= eqrqs_pkg::A_QEXP &&
          ai < eqrqs_pkg::A_QEXP + NQ * 4) begin
        d.rg = eqrqs_pkg::RG_QEXP;
        d.q = eqrqs_pkg::Q_W'((ai - eqrqs_pkg::A_QEXP) / 4);
      end else if (ai >= eqrqs_pkg::A_SEL &&
          ai < eqrqs_pkg::A_SEL + eqrqs_pkg::SEL_N * 4) begin
        d.rg = eqrqs_pkg::RG_SEL;
        d.idx = 8'((ai - eqrqs_pkg::A_SEL) / 4);
      end else if (ai >= eqrqs_pkg::A_MAP &&
          ai < eqrqs_pkg::A_MAP + eqrqs_pkg::MAP_N * 4) begin
        d.rg = eqrqs_pkg::RG_MAP;
        d.idx = 8'((ai - eqrqs_pkg::A_MAP) / 4);
      end
    end
    return d;
  endfunction

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nv,
      logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (old & ~m) | (nv & m);
  endfunction

  // both remap stages for one departing packet
  function automatic eqrqs_pkg::eqrqs_out_s remap(
      eqrqs_pkg::eqrqs_enq_s d);
    eqrqs_pkg::eqrqs_out_s o;
    eqrqs_pkg::eqrqs_pcfg_s pc;
    eqrqs_pkg::eqrqs_sel_s sl;
    eqrqs_pkg::eqrqs_map_s e;
    logic [3:0] mi;
    logic ip;
    o.port = d.port;
    o.queue = d.queue;
    o.ptr = d.ptr;
    o.cells = d.cells;
    o.strip_tags = (d.fwd_type == eqrqs_pkg::EQRQS_ROUTED);
    o.add_inner = o.strip_tags && d.add_inner_next_hop_tag;
    o.add_outer = o.strip_tags && d.add_outer_next_hop_tag;
    o.inner_pcp = d.pcp;
    o.inner_dei = d.dei;
    o.outer_pcp = d.pcp;
    o.outer_dei = d.dei;
    o.pcp = d.pcp;
    o.dei = d.dei;
    o.exp = d.exp;
    o.tos = d.tos;
    pc = pcfg_ff[d.port];
    if (o.add_inner && d.inner_tag_priority_source)
      o.inner_pcp = rqv_ff[d.queue][2:0];
    if (o.add_inner && d.inner_tag_drop_bit_source)
      o.inner_dei = rqv_ff[d.queue][3];
    if (o.add_outer && d.outer_tag_priority_source)
      o.outer_pcp = rqv_ff[d.queue][2:0];
    if (o.add_outer && d.outer_tag_drop_bit_source)
      o.outer_dei = rqv_ff[d.queue][3];
    if (pc.port_tag_operation == eqrqs_pkg::EQRQS_OP_PUSH ||
        pc.port_tag_operation == eqrqs_pkg::EQRQS_OP_SWAP) begin
      if (pc.port_priority_source) o.pcp = qpd_ff[d.queue][2:0];
      if (pc.port_drop_bit_source) o.dei = qpd_ff[d.queue][3];
    end
    if ((d.label_operation == eqrqs_pkg::EQRQS_OP_PUSH ||
        d.label_operation == eqrqs_pkg::EQRQS_OP_SWAP) &&
        d.label_class_source)
      o.exp = qexp_ff[d.queue];
    ip = (d.pkt_type == eqrqs_pkg::EQRQS_IPV4 ||
        d.pkt_type == eqrqs_pkg::EQRQS_IPV6);
    sl = sel_ff[{d.port, d.pkt_type, d.fwd_type}];
    case (sl.kind)
      eqrqs_pkg::EQRQS_MAP_L2: mi = {o.pcp, o.dei};
      eqrqs_pkg::EQRQS_MAP_IP: mi = {2'h0, o.tos[1:0]};
      eqrqs_pkg::EQRQS_MAP_TOS: mi = o.tos[7:4];
      default: mi = {o.exp, o.dei};
    endcase
    e = map_ff[{sl.kind, sl.mapping_table_pointer, mi}];
    if (map_en_ff) begin
      case (sl.kind)
        eqrqs_pkg::EQRQS_MAP_L2: begin
          o.pcp = e.pcp;
          o.dei = e.dei;
        end
        eqrqs_pkg::EQRQS_MAP_IP: begin
          if (ip) o.tos = {o.tos[7:2], e.tos[1:0]};
        end
        eqrqs_pkg::EQRQS_MAP_TOS: begin
          if (ip) begin
            o.tos = e.tos;
            o.pcp = e.pcp;
            o.dei = e.dei;
            if (d.label_operation == eqrqs_pkg::EQRQS_OP_PUSH) o.exp = e.exp;
          end
        end
        default: begin
          if (d.pkt_type == eqrqs_pkg::EQRQS_MPLS) begin
            o.pcp = e.pcp;
            o.dei = e.dei;
            o.exp = e.exp;
          end
        end
      endcase
    end
    return o;
  endfunction

  // scheduling: one port per cycle in turn, strict priority inside it
  logic [NQ-1:0] nonempty;
  logic [NQ-1:0] elig;
  logic [eqrqs_pkg::Q_W-1:0] tx_q;
  logic [eqrqs_pkg::Q_W-1:0] dr_q;
  logic [eqrqs_pkg::Q_W-1:0] pop_q;
  logic tx_pop;
  logic dr_pop;
  logic pop;
  eqrqs_pkg::eqrqs_enq_s head;

  always_comb begin
    nonempty = '0;
    for (int q = 0; q < NQ; q++) nonempty[q] = (cnt_ff[rr_ff][q] != '0);
    elig = nonempty & ~out_dis_ff[rr_ff];
    tx_q = '0;
    dr_q = '0;
    for (int q = NQ - 1; q >= 0; q--) begin
      if (elig[q]) tx_q = eqrqs_pkg::Q_W'(q);
      if (nonempty[q]) dr_q = eqrqs_pkg::Q_W'(q);
    end
    dr_pop = drain_ff[rr_ff] && (nonempty != '0);
    tx_pop = !drain_ff[rr_ff] && (elig != '0) && (!out_valid || out_ready);
    pop = dr_pop || tx_pop;
    pop_q = dr_pop ? dr_q : tx_q;
    head = qmem_ff[rr_ff][pop_q][rp_ff[rr_ff][pop_q]];
  end

  logic enq_take;
  logic enq_acc;
  always_comb begin
    enq_take = enq_valid && enq_ready;
    enq_acc = enq_take && enq_en_ff[enq_data.port][enq_data.queue] &&
        (cnt_ff[enq_data.port][enq_data.queue] != CNT_W'(QDEPTH));
  end

  // fifo per queue; pointers only advance so order is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < NPORT; p++)
        for (int q = 0; q < NQ; q++) begin
          wp_ff[p][q] <= '0;
          rp_ff[p][q] <= '0;
          cnt_ff[p][q] <= '0;
        end
    end else begin
      for (int p = 0; p < NPORT; p++)
        for (int q = 0; q < NQ; q++) begin
          if (enq_acc && enq_data.port == p && enq_data.queue == q) begin
            qmem_ff[p][q][wp_ff[p][q]] <= enq_data;
            wp_ff[p][q] <= wp_ff[p][q] + 1'b1;
          end
          if (pop && rr_ff == p && pop_q == q)
            rp_ff[p][q] <= rp_ff[p][q] + 1'b1;
          cnt_ff[p][q] <= cnt_ff[p][q]
              + CNT_W'(enq_acc && enq_data.port == p && enq_data.queue == q)
              - CNT_W'(pop && rr_ff == p && pop_q == q);
        end
    end
  end

  logic [FW-1:0] nxt_free;
  always_comb begin
    nxt_free = free_ff - (enq_acc ? FW'(enq_data.cells) : '0)
        + (pop ? FW'(head.cells) : '0);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      free_ff <= FW'(BUF_CELLS);
      min_free_ff <= FW'(BUF_CELLS);
      enq_ready <= 1'b0;
      rr_ff <= '0;
      empty_ff <= '1;
    end else begin
      free_ff <= nxt_free;
      if (nxt_free < min_free_ff) min_free_ff <= nxt_free;
      // worst case one more packet must still fit
      enq_ready <= (nxt_free >= FW'(CMAX)) && (nxt_free != '0);
      rr_ff <= (rr_ff == eqrqs_pkg::PORT_W'(NPORT - 1)) ? '0 : rr_ff + 1'b1;
      for (int p = 0; p < NPORT; p++) begin
        empty_ff[p] <= 1'b1;
        for (int q = 0; q < NQ; q++)
          if (cnt_ff[p][q] != '0) empty_ff[p] <= 1'b0;
      end
    end
  end

  // drop counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < NPORT; p++) begin
        qoff_ff[p] <= '0;
        ddrop_ff[p] <= '0;
      end
    end else begin
      if (enq_take && !enq_acc)
        qoff_ff[enq_data.port] <= qoff_ff[enq_data.port] + 1'b1;
      if (dr_pop) ddrop_ff[rr_ff] <= ddrop_ff[rr_ff] + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (tx_pop) begin
      out_valid <= 1'b1;
      out_data <= remap(head);
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  // axi4-lite write channel
  eqrqs_dec_s wd;
  logic wr_go;
  always_comb begin
    wd = decode(waddr_ff);
    wr_go = aw_have_ff && w_have_ff && !bvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= eqrqs_pkg::RESP_OK;
      waddr_ff <= '0;
      wdat_ff <= '0;
      wstb_ff <= '0;
    end else begin
      if (awvalid && awready) begin
        waddr_ff <= awaddr;
        aw_have_ff <= 1'b1;
        awready <= 1'b0;
      end else if (!aw_have_ff && !bvalid) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        wdat_ff <= wdata;
        wstb_ff <= wstrb;
        w_have_ff <= 1'b1;
        wready <= 1'b0;
      end else if (!w_have_ff && !bvalid) begin
        wready <= 1'b1;
      end
      if (wr_go) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (wd.rg == eqrqs_pkg::RG_NONE) ? eqrqs_pkg::RESP_DECERR
            : eqrqs_pkg::RESP_OK;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // software-written control; status registers ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      map_en_ff <= 1'b0;
      drain_ff <= '0;
      for (int p = 0; p < NPORT; p++) begin
        out_dis_ff[p] <= '0;
        enq_en_ff[p] <= eqrqs_pkg::ENQ_EN_RST;
        pcfg_ff[p] <= '0;
      end
    end else if (wr_go) begin
      case (wd.rg)
        eqrqs_pkg::RG_CTRL: if (wstb_ff[0]) map_en_ff <= wdat_ff[0];
        eqrqs_pkg::RG_OUTDIS:
          if (wstb_ff[0]) out_dis_ff[wd.port] <= wdat_ff[NQ-1:0];
        eqrqs_pkg::RG_ENQEN:
          if (wstb_ff[0]) enq_en_ff[wd.port] <= wdat_ff[NQ-1:0];
        eqrqs_pkg::RG_DRAIN:
          if (wstb_ff[0]) drain_ff[wd.port] <= wdat_ff[0];
        eqrqs_pkg::RG_PCFG:
          if (wstb_ff[0]) pcfg_ff[wd.port] <= wdat_ff[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int q = 0; q < NQ; q++) begin
        rqv_ff[q] <= '0;
        qpd_ff[q] <= '0;
        qexp_ff[q] <= '0;
      end
      for (int i = 0; i < eqrqs_pkg::SEL_N; i++) sel_ff[i] <= '0;
      for (int i = 0; i < eqrqs_pkg::MAP_N; i++) map_ff[i] <= '0;
    end else if (wr_go) begin
      case (wd.rg)
        eqrqs_pkg::RG_RQV: if (wstb_ff[0]) rqv_ff[wd.q] <= wdat_ff[3:0];
        eqrqs_pkg::RG_QPD: if (wstb_ff[0]) qpd_ff[wd.q] <= wdat_ff[3:0];
        eqrqs_pkg::RG_QEXP: if (wstb_ff[0]) qexp_ff[wd.q] <= wdat_ff[2:0];
        eqrqs_pkg::RG_SEL: if (wstb_ff[0]) sel_ff[wd.idx] <= wdat_ff[2:0];
        eqrqs_pkg::RG_MAP:
          map_ff[wd.idx[6:0]] <= eqrqs_pkg::MAP_EW'(merge(
              32'(map_ff[wd.idx[6:0]]), wdat_ff, wstb_ff));
        default: ;
      endcase
    end
  end

  // axi4-lite read channel
  eqrqs_dec_s rd;
  logic [31:0] rval;
  always_comb begin
    rd = decode(araddr);
    rval = '0;
    case (rd.rg)
      eqrqs_pkg::RG_CTRL: rval = 32'(map_en_ff);
      eqrqs_pkg::RG_FREE: rval = 32'(free_ff);
      eqrqs_pkg::RG_MINFREE: rval = 32'(min_free_ff);
      eqrqs_pkg::RG_EMPTY: rval = 32'(empty_ff);
      eqrqs_pkg::RG_OUTDIS: rval = 32'(out_dis_ff[rd.port]);
      eqrqs_pkg::RG_ENQEN: rval = 32'(enq_en_ff[rd.port]);
      eqrqs_pkg::RG_DRAIN: rval = 32'(drain_ff[rd.port]);
      eqrqs_pkg::RG_PCFG: rval = 32'(pcfg_ff[rd.port]);
      eqrqs_pkg::RG_PDEPTH:
        for (int q = 0; q < NQ; q++)
          rval = rval + 32'(cnt_ff[rd.port][q]);
      eqrqs_pkg::RG_QOFF: rval = qoff_ff[rd.port];
      eqrqs_pkg::RG_DDROP: rval = ddrop_ff[rd.port];
      eqrqs_pkg::RG_QDEPTH: rval = 32'(cnt_ff[rd.port][rd.q]);
      eqrqs_pkg::RG_RQV: rval = 32'(rqv_ff[rd.q]);
      eqrqs_pkg::RG_QPD: rval = 32'(qpd_ff[rd.q]);
      eqrqs_pkg::RG_QEXP: rval = 32'(qexp_ff[rd.q]);
      eqrqs_pkg::RG_SEL: rval = 32'(sel_ff[rd.idx]);
      eqrqs_pkg::RG_MAP: rval = 32'(map_ff[rd.idx[6:0]]);
      default: rval = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= eqrqs_pkg::RESP_OK;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rval;
      rresp <= (rd.rg == eqrqs_pkg::RG_NONE) ? eqrqs_pkg::RESP_DECERR
          : eqrqs_pkg::RESP_OK;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end
endmodule

// ### test/eqrqs_asserts.sv
// port checks for the egress qos block
`timescale 1ns/10ps
module eqrqs_asserts #(
  parameter int NPORT = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire eqrqs_pkg::eqrqs_out_s out_data,
  input wire logic out_valid,
  input wire logic out_ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_b_once: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  chk_wr_busy: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  chk_rd_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  chk_rd_busy: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");
  chk_r_once: assert property (rvalid && rready |=> !rvalid)
    else $error("read data repeated");
  chk_r_decerr: assert property (rvalid && rresp == 2'h3 |-> rdata == '0)
    else $error("refused read carries data");
  chk_out_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output changed while stalled");
  chk_out_port: assert property (out_valid |-> out_data.port < NPORT)
    else $error("output port out of range");
  cover property (out_valid && out_ready);
  cover property (bvalid && bready);
  cover property (rvalid && rresp == 2'h3);
endmodule
bind eqrqs_top eqrqs_asserts #(.NPORT(NPORT)) u_chk (.aclk, .aresetn,
  .awready, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid,
  .rready, .rdata, .rresp, .out_data, .out_valid, .out_ready);

// ### test/eqrqs_sink.sv
// egress pipeline model, takes packets with random stalls
`timescale 1ns/10ps
module eqrqs_sink (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hold,
  output logic out_ready
);
  initial out_ready = 1'b0;
  // hold lets the bench freeze the pipeline during setup
  always @(posedge aclk)
    out_ready <= aresetn && !hold && $urandom % 4 != 0;
endmodule

// ### test/eqrqs_top_bench.sv
// self-checking bench for the egress qos block
`timescale 1ns/10ps
module eqrqs_top_bench;
  logic aclk = 0;
  logic aresetn = 0;
  logic awvalid = 0, wvalid = 0, arvalid = 0, enq_valid = 0, hold = 1;
  logic awready, wready, bvalid, arready, rvalid, enq_ready, out_valid;
  logic out_ready;
  logic [15:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, v;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] ptrs [8];
  eqrqs_pkg::eqrqs_enq_s enq_data = '0;
  eqrqs_pkg::eqrqs_out_s out_data, o;
  eqrqs_pkg::eqrqs_fwd_e fwd = eqrqs_pkg::EQRQS_SWITCHED;
  int err_count = 0, checked = 0, p, i;
  always #25 aclk = ~aclk;
  eqrqs_top u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready(1'b1),
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready(1'b1),
    .enq_data, .enq_valid, .enq_ready, .out_data, .out_valid, .out_ready);
  eqrqs_sink u_sink (.aclk, .aresetn, .hold, .out_ready);
  function int pa(input int f);
    return eqrqs_pkg::A_PORT + p * eqrqs_pkg::PSTRIDE + f;
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input int a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a[15:0]; wdata <= d; awvalid <= 1; wvalid <= 1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    rs = bresp;
  endtask
  task rd(input int a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a[15:0]; arvalid <= 1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata; rs = rresp;
  endtask
  task enq(input int q);
    eqrqs_pkg::eqrqs_enq_s d;
    @(posedge aclk);
    d = '0; d.port = p[3:0]; d.queue = q[2:0]; d.cells = 4'h2;
    d.fwd_type = fwd;
    d.add_inner_next_hop_tag = 1'b1;
    d.inner_tag_priority_source = 1'b1;
    d.ptr = 8'($urandom); d.pcp = 3'($urandom); d.tos = 8'($urandom);
    ptrs[q] = d.ptr; enq_data <= d; enq_valid <= 1;
    do @(posedge aclk); while (!enq_ready);
    enq_valid <= 0;
  endtask
  // waits for one packet and checks where it came from
  task get(input int q);
    do @(posedge aclk); while (!(out_valid && out_ready));
    o = out_data;
    chk({o.port, o.queue, o.ptr}, {p[3:0], q[2:0], ptrs[q]});
  endtask
  task end_sim;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    end_sim;
  end
  initial begin
    i = $urandom(32'h05e954c0);
    p = $urandom % 12;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rd(eqrqs_pkg::A_FREE, v); chk(v, 1024);
    rd(eqrqs_pkg::A_EMPTY, v); chk(v, 32'hfff);
    rd(pa(eqrqs_pkg::F_ENQEN), v); chk(v, 32'hff);
    rd('h10, v); chk(rs, 2'h3);
    wr('h10, 32'h0); chk(rs, 2'h3);
    $display("test 1 end");
    hold <= 0;
    wr(pa(eqrqs_pkg::F_PCFG), 32'h7);
    chk(rs, 2'h0);
    wr(eqrqs_pkg::A_QPD + 12, 32'hd);
    enq(3);
    get(3);
    chk({o.pcp, o.dei}, 4'hb);
    $display("test 2 end");
    // second stage: l2 table, pointer one, indexed by first stage pcp/dei
    wr(eqrqs_pkg::A_CTRL, 32'h1);
    wr(eqrqs_pkg::A_SEL + p * 64, 32'h1);
    wr(eqrqs_pkg::A_MAP + 'h6c, 32'h200);
    enq(3);
    get(3);
    chk({o.pcp, o.dei}, 4'h4);
    wr(eqrqs_pkg::A_RQV + 12, 32'h6);
    fwd = eqrqs_pkg::EQRQS_ROUTED;
    enq(3);
    get(3);
    chk({o.strip_tags, o.add_inner, o.inner_pcp}, 5'h1e);
    $display("test 2b end");
    hold <= 1;
    wr(pa(eqrqs_pkg::F_OUTDIS), 32'hff);
    enq(7); enq(5); enq(2);
    rd(pa(eqrqs_pkg::F_PDEPTH), v); chk(v, 3);
    rd(pa(eqrqs_pkg::A_QDEPTH - eqrqs_pkg::A_PORT + 20), v); chk(v, 1);
    rd(eqrqs_pkg::A_FREE, v); chk(v, 1018);
    rd(eqrqs_pkg::A_MINFREE, v); chk(v, 1018);
    wr(pa(eqrqs_pkg::F_OUTDIS), 32'h04);
    hold <= 0;
    get(5);
    get(7);
    rd(pa(eqrqs_pkg::F_PDEPTH), v); chk(v, 1);
    wr(pa(eqrqs_pkg::F_OUTDIS), 32'h0);
    get(2);
    $display("test 3 end");
    wr(pa(eqrqs_pkg::F_ENQEN), 32'hf7);
    enq(3);
    rd(pa(eqrqs_pkg::F_QOFF), v); chk(v, 1);
    rd(pa(eqrqs_pkg::F_PDEPTH), v); chk(v, 0);
    wr(pa(eqrqs_pkg::F_ENQEN), 32'hff);
    $display("test 4 end");
    wr(pa(eqrqs_pkg::F_OUTDIS), 32'hff);
    enq(0); enq(6);
    rd(eqrqs_pkg::A_EMPTY, v); chk(v[p], 0);
    wr(pa(eqrqs_pkg::F_ENQEN), 32'h0);
    wr(pa(eqrqs_pkg::F_DRAIN), 32'h1);
    for (i = 0; i < 40 && !v[p]; i++) rd(eqrqs_pkg::A_EMPTY, v);
    chk(v[p], 1);
    rd(pa(eqrqs_pkg::F_DDROP), v); chk(v, 2);
    rd(eqrqs_pkg::A_FREE, v); chk(v, 1024);
    $display("test 5 end");
    end_sim;
  end
endmodule
